// ---- shared/flash_seq_pkg.sv ----
//==========================================================================
// Purpose: constants and types shared by the flash self-program sequencer
// Assumes: 16-bit register port, 200 MHz core clock
// Notes:   offsets are word indices on the plain register port
//
// Functional notes
// - operation lasts 4 ms, core stalled meanwhile
// - bit 15 launches; hardware clears it when done
// - software only sets launch bit; resets zero
// - bit 14 permits or inhibits modify operations
// - bit 13 flags improper sequence on launch attempts
// - bit 6 selects erase or program
// - codes 1111, 0010, 0001; mismatches do nothing
// - other operation codes are unimplemented
// - control bits reset only at power-on
// - bits 12-7 and 5-4 read zero
// - keys 55h then AAh precede launch
// - key port is write-only protection
//==========================================================================
package flash_seq_pkg;

    localparam int DATA_W = 16;
    localparam int ADDR_W = 4;

    // ======================================================================
    // register map
    localparam logic [ADDR_W-1:0] CTRL_ADDR = 4'h0;
    localparam logic [ADDR_W-1:0] KEY_ADDR = 4'h1;
    localparam logic [ADDR_W-1:0] IRQ_STS_ADDR = 4'h2;
    localparam logic [ADDR_W-1:0] IRQ_MSK_ADDR = 4'h3;

    // ======================================================================
    // control register fields
    localparam int LAUNCH_BIT = 15;
    localparam int PERMIT_BIT = 14;
    localparam int FAULT_BIT = 13;
    localparam int ERASE_BIT = 6;
    localparam int OPSEL_LSB = 0;
    localparam int OPSEL_W = 4;

    localparam logic [OPSEL_W-1:0] OPSEL_BULK_ERASE = 4'hf;
    localparam logic [OPSEL_W-1:0] OPSEL_ROW_ERASE = 4'h2;
    localparam logic [OPSEL_W-1:0] OPSEL_ROW_PROGRAM = 4'h1;
    localparam logic [OPSEL_W-1:0] OPSEL_RESET = 4'h0;

    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;

    // ======================================================================
    // interrupt status / mask layout
    localparam int IRQ_W = 2;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_FAULT_BIT = 1;

    // ======================================================================
    // timing
    localparam int OP_TIME_NS = 4_000_000;
    localparam int CLK_PERIOD_NS = 5;
    localparam int OP_CYCLES_DEFAULT = OP_TIME_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        OP_NONE,
        OP_BULK_ERASE,
        OP_ROW_ERASE,
        OP_ROW_PROGRAM
    } op_kind_type;

    typedef enum logic [1:0] {
        KEY_LOCKED,
        KEY_HALF,
        KEY_ARMED
    } key_state_type;

    typedef enum logic {
        SEQ_IDLE,
        SEQ_BUSY
    } seq_state_type;

endpackage

// ---- verilog/flash_self_program_sequencer.sv ----
//==========================================================================
// Purpose: operation control, unlock check and self-timing for run-time
//          self-programming of the on-chip program flash
// Assumes: rst_i is the power-on reset; other resets never reach here
// Notes:   the array itself is outside; this block issues a one-cycle
//          start with the decoded operation and holds the core stalled
//==========================================================================
`timescale 1ns/1ps

module flash_self_program_sequencer #(
    parameter int OP_CYCLES = flash_seq_pkg::OP_CYCLES_DEFAULT
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [flash_seq_pkg::ADDR_W-1:0] addr_i,
    input wire logic [flash_seq_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [flash_seq_pkg::DATA_W-1:0] rdata_o,
    output logic core_stall_o,
    output logic flash_start_o,
    output flash_seq_pkg::op_kind_type flash_op_o,
    output logic irq_o
);
    import flash_seq_pkg::*;

    localparam int CNT_W = $clog2(OP_CYCLES + 1);

    // ======================================================================
    // elaboration check
    generate
        if (OP_CYCLES < 1) begin : g_bad_cycles
            $error("OP_CYCLES must be at least one");
        end
    endgenerate

    // ======================================================================
    // decode helpers
    function automatic op_kind_type decode_op(
        input logic erase,
        input logic [OPSEL_W-1:0] sel
    );
        op_kind_type kind;
        kind = OP_NONE;
        // mismatched erase select and any other code fall to no operation
        case (sel)
            OPSEL_BULK_ERASE: kind = erase ? OP_BULK_ERASE : OP_NONE;
            OPSEL_ROW_ERASE: kind = erase ? OP_ROW_ERASE : OP_NONE;
            OPSEL_ROW_PROGRAM: kind = erase ? OP_NONE : OP_ROW_PROGRAM;
            default: kind = OP_NONE;
        endcase
        return kind;
    endfunction

    // ======================================================================
    // state
    logic launch_q, launch_d;
    logic permit_q, permit_d;
    logic fault_q, fault_d;
    logic erase_q, erase_d;
    logic [OPSEL_W-1:0] opsel_q, opsel_d;
    key_state_type key_q, key_d;
    seq_state_type seq_q, seq_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [IRQ_W-1:0] sts_q, sts_d;
    logic [IRQ_W-1:0] msk_q, msk_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic start_q, start_d;
    op_kind_type op_q, op_d;
    logic irq_q, irq_d;

    // ======================================================================
    // bus decode
    wire ctrl_wr = wr_i && (addr_i == CTRL_ADDR);
    wire key_wr = wr_i && (addr_i == KEY_ADDR);
    wire sts_wr = wr_i && (addr_i == IRQ_STS_ADDR);
    wire msk_wr = wr_i && (addr_i == IRQ_MSK_ADDR);
    wire [7:0] key_byte = wdata_i[7:0];

    wire busy = (seq_q == SEQ_BUSY);
    wire op_done = busy && (cnt_q == '0);

    // every write of a one to the launch bit is an attempt to be checked
    wire launch_try = ctrl_wr && wdata_i[LAUNCH_BIT];
    wire w_permit = wdata_i[PERMIT_BIT];
    wire w_erase = wdata_i[ERASE_BIT];
    wire [OPSEL_W-1:0] w_opsel = wdata_i[OPSEL_LSB +: OPSEL_W];
    wire op_kind_type w_kind = decode_op(w_erase, w_opsel);

    // permit comes from the same write, so one store can permit and launch
    wire seq_ok = (key_q == KEY_ARMED) && w_permit && !busy;
    wire launch_ok = launch_try && seq_ok && (w_kind != OP_NONE);
    wire launch_bad = launch_try && !seq_ok;

    // ======================================================================
    // unlock key tracking
    always_comb begin
        key_d = key_q;
        if (key_wr) begin
            // key port only ever steps the unlock, it stores nothing
            case (key_q)
                KEY_LOCKED:
                    key_d = (key_byte == KEY_FIRST) ? KEY_HALF : KEY_LOCKED;
                KEY_HALF: begin
                    if (key_byte == KEY_SECOND) begin
                        key_d = KEY_ARMED;
                    end else if (key_byte == KEY_FIRST) begin
                        key_d = KEY_HALF;
                    end else begin
                        key_d = KEY_LOCKED;
                    end
                end
                KEY_ARMED:
                    key_d = (key_byte == KEY_FIRST) ? KEY_HALF : KEY_LOCKED;
                default: key_d = KEY_LOCKED;
            endcase
        end else if (wr_i) begin
            key_d = KEY_LOCKED;
        end
    end

    // ======================================================================
    // control register and operation timer
    always_comb begin
        launch_d = launch_q;
        permit_d = permit_q;
        fault_d = fault_q;
        erase_d = erase_q;
        opsel_d = opsel_q;
        seq_d = seq_q;
        cnt_d = cnt_q;
        start_d = 1'b0;
        op_d = op_q;
        // settings are frozen while an operation runs
        if (ctrl_wr && !busy) begin
            permit_d = w_permit;
            erase_d = w_erase;
            opsel_d = w_opsel;
            fault_d = wdata_i[FAULT_BIT];
        end
        case (seq_q)
            SEQ_IDLE: begin
                if (launch_ok) begin
                    launch_d = 1'b1;
                    seq_d = SEQ_BUSY;
                    cnt_d = CNT_W'(OP_CYCLES - 1);
                    start_d = 1'b1;
                    op_d = w_kind;
                end
            end
            SEQ_BUSY: begin
                if (op_done) begin
                    launch_d = 1'b0;
                    seq_d = SEQ_IDLE;
                    op_d = OP_NONE;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            default: begin
                seq_d = SEQ_IDLE;
                launch_d = 1'b0;
            end
        endcase
        // a fault raised in the same write wins over a software clear
        if (launch_bad) begin
            fault_d = 1'b1;
        end
    end

    // ======================================================================
    // interrupt status, write one to clear, new events win
    always_comb begin
        sts_d = sts_q;
        msk_d = msk_q;
        if (sts_wr) begin
            sts_d = sts_q & ~wdata_i[IRQ_W-1:0];
        end
        if (msk_wr) begin
            msk_d = wdata_i[IRQ_W-1:0];
        end
        if (op_done) begin
            sts_d[IRQ_DONE_BIT] = 1'b1;
        end
        if (launch_bad) begin
            sts_d[IRQ_FAULT_BIT] = 1'b1;
        end
        irq_d = |(sts_d & msk_d);
    end

    // ======================================================================
    // read path, data stands the cycle after the strobe only
    wire [DATA_W-1:0] ctrl_view = {
        launch_q, permit_q, fault_q,
        6'h00,
        erase_q,
        2'h0,
        opsel_q
    };
    wire [DATA_W-1:0] sts_view = {{(DATA_W-IRQ_W){1'b0}}, sts_q};
    wire [DATA_W-1:0] msk_view = {{(DATA_W-IRQ_W){1'b0}}, msk_q};

    always_comb begin
        rdata_d = '0;
        if (rd_i) begin
            case (addr_i)
                CTRL_ADDR: rdata_d = ctrl_view;
                IRQ_STS_ADDR: rdata_d = sts_view;
                IRQ_MSK_ADDR: rdata_d = msk_view;
                // write-only key port and unmapped space read zero
                default: rdata_d = '0;
            endcase
        end
    end

    // ======================================================================
    // flip-flops; rst_i is power-on only so bits survive other resets
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            launch_q <= 1'b0;
            permit_q <= 1'b0;
            fault_q <= 1'b0;
            erase_q <= 1'b0;
            opsel_q <= OPSEL_RESET;
            seq_q <= SEQ_IDLE;
            key_q <= KEY_LOCKED;
            cnt_q <= '0;
        end else begin
            launch_q <= launch_d;
            permit_q <= permit_d;
            fault_q <= fault_d;
            erase_q <= erase_d;
            opsel_q <= opsel_d;
            seq_q <= seq_d;
            key_q <= key_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            sts_q <= '0;
            msk_q <= '0;
            irq_q <= 1'b0;
            rdata_q <= '0;
            start_q <= 1'b0;
            op_q <= OP_NONE;
        end else begin
            sts_q <= sts_d;
            msk_q <= msk_d;
            irq_q <= irq_d;
            rdata_q <= rdata_d;
            start_q <= start_d;
            op_q <= op_d;
        end
    end

    // ======================================================================
    // outputs
    assign rdata_o = rdata_q;
    assign core_stall_o = launch_q;
    assign flash_start_o = start_q;
    assign flash_op_o = op_q;
    assign irq_o = irq_q;

endmodule // flash_self_program_sequencer

// ---- verif/core_model.sv ----
// Purpose: processor core issuing register accesses to the sequencer
// Assumes: one-cycle strobes, the slave never stalls the bus
// Notes: released data lines flip so a stale value never matches
`timescale 1ns/1ps
module core_model (
    input wire logic core_clk_i,
    output logic [flash_seq_pkg::ADDR_W-1:0] addr_o,
    output logic [flash_seq_pkg::DATA_W-1:0] wdata_o,
    output logic wr_o,
    output logic rd_o
);
    import flash_seq_pkg::*;
    initial begin
        addr_o = '0;
        wdata_o = '0;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    //==========
    // bus cycles
    task automatic acc(input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d, input logic w);
        @(posedge core_clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= w;
        rd_o <= !w;
    endtask
    task automatic rest();
        @(posedge core_clk_i);
        wr_o <= 1'b0;
        rd_o <= 1'b0;
        wdata_o <= ~wdata_o;
    endtask
    // no write may slip in between keys and launch
    task automatic unlock(input logic swap);
        acc(KEY_ADDR, swap ? 16'h00aa : 16'h0055, 1'b1);
        acc(KEY_ADDR, swap ? 16'h0055 : 16'h00aa, 1'b1);
    endtask
endmodule // core_model

// ---- verif/flash_seq_asserts.sv ----
// Purpose: port properties of the flash self-program sequencer
// Assumes: one clock, rst_i synchronous active high
// Notes: OP_CYCLES comes from the bound instance
`timescale 1ns/1ps
module flash_seq_checker #(
    parameter int OP_CYCLES = 20
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [flash_seq_pkg::ADDR_W-1:0] addr_i,
    input wire logic [flash_seq_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [flash_seq_pkg::DATA_W-1:0] rdata_o,
    input wire logic core_stall_o,
    input wire logic flash_start_o,
    input flash_seq_pkg::op_kind_type flash_op_o,
    input wire logic irq_o
);
    import flash_seq_pkg::*;
    int busy_n;
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);
    //==========
    // stall length counter
    always_ff @(posedge core_clk_i) begin
        busy_n <= (rst_i || !core_stall_o) ? 0 : busy_n + 1;
    end
    stall_len_a: assert property (
        $fell(core_stall_o) |-> busy_n == OP_CYCLES) else $error("stall len");
    start_stall_a: assert property (
        flash_start_o |-> core_stall_o && !$past(core_stall_o))
        else $error("start without stall");
    start_pulse_a: assert property (
        flash_start_o |=> !flash_start_o) else $error("start too long");
    start_kind_a: assert property (
        flash_start_o |-> flash_op_o != OP_NONE) else $error("empty op");
    launch_read_a: assert property (
        rd_i && addr_i == CTRL_ADDR |=> rdata_o[15] == $past(core_stall_o)
        && rdata_o[12:7] == '0 && rdata_o[5:4] == '0) else $error("ctrl read");
    key_read_a: assert property (
        rd_i && addr_i == KEY_ADDR |=> rdata_o == '0) else $error("key read");
    permit_gate_a: assert property (
        wr_i && addr_i == CTRL_ADDR && wdata_i[15] && !wdata_i[14]
        |=> !flash_start_o) else $error("start without permit");
    key_used_a: assert property (
        wr_i && addr_i == CTRL_ADDR && wdata_i[15] && $past(wr_i)
        && $past(addr_i) != KEY_ADDR |=> !flash_start_o)
        else $error("start without fresh keys");
endmodule // flash_seq_checker
bind flash_self_program_sequencer flash_seq_checker #(
    .OP_CYCLES(OP_CYCLES)) u_chk (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .core_stall_o(core_stall_o),
    .flash_start_o(flash_start_o), .flash_op_o(flash_op_o), .irq_o(irq_o));

// ---- verif/flash_self_program_sequencer_tb.sv ----
// Purpose: self-checking bench for the flash self-program sequencer
// Assumes: operation time shortened to CYC cycles
// Notes: reads and starts are matched against queued expectations
`timescale 1ns/1ps
module flash_self_program_sequencer_tb;
    import flash_seq_pkg::*;
    localparam int CYC = 20;
    logic core_clk_i;
    logic rst_i;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic wr, rd, stall, start, irq;
    op_kind_type op;
    logic pend = 1'b0;
    logic [1:0] msk = 2'b00;
    logic [31:0] r;
    int failures = 0;
    int comparisons = 0;
    integer seed = 32'hb77c6136;
    logic [DATA_W-1:0] exp_rd[$];
    op_kind_type exp_op[$];
    logic [DATA_W-1:0] fixed[7] = '{16'h4042, 16'h404f, 16'h4001,
        16'h4002, 16'h4041, 16'h4045, 16'h0001};
    core_model u_core (.core_clk_i(core_clk_i), .addr_o(addr),
        .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
    flash_self_program_sequencer #(.OP_CYCLES(CYC)) u_dut (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .core_stall_o(stall), .flash_start_o(start), .flash_op_o(op),
        .irq_o(irq));
    initial begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end
    task automatic check(input logic ok, input string m);
        comparisons++;
        if (ok !== 1'b1) begin
            failures++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask
    task automatic conclude();
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    //==========
    // result watcher
    always @(negedge core_clk_i) begin
        if (pend) check(exp_rd.size() > 0 && rdata === exp_rd.pop_front(),
            "read data");
        if (start) check(exp_op.size() > 0 && op === exp_op.pop_front(),
            "operation");
        pend = rd;
    end
    function automatic op_kind_type kind(input logic [DATA_W-1:0] d);
        case ({d[ERASE_BIT], d[3:0]})
            5'h1f: kind = OP_BULK_ERASE;
            5'h12: kind = OP_ROW_ERASE;
            5'h01: kind = OP_ROW_PROGRAM;
            default: kind = OP_NONE;
        endcase
    endfunction
    task automatic irq_is(input logic e);
        @(negedge core_clk_i);
        check(irq === e, "interrupt line");
    endtask
    task automatic setmask(input logic [1:0] m);
        msk = m;
        u_core.acc(IRQ_MSK_ADDR, {14'h0, m}, 1'b1);
    endtask
    task automatic launch(input logic [DATA_W-1:0] d, input logic [1:0] mode);
        logic bad;
        logic go;
        d &= 16'h404f;
        bad = mode != 2'd0 || !d[PERMIT_BIT];
        go = !bad && kind(d) != OP_NONE;
        u_core.unlock(mode[0]);
        if (mode == 2'd2) u_core.acc(CTRL_ADDR, d, 1'b1);
        u_core.acc(CTRL_ADDR, d | 16'h8000, 1'b1);
        if (go) exp_op.push_back(kind(d));
        u_core.acc(CTRL_ADDR, '0, 1'b0);
        exp_rd.push_back(d | {go, 1'b0, bad, 13'h0});
        u_core.rest();
        u_core.rest();
        for (int n = 0; n < 2 * CYC && stall !== 1'b0; n++)
            @(negedge core_clk_i);
        u_core.acc(CTRL_ADDR, '0, 1'b0);
        exp_rd.push_back(d | {2'b0, bad, 13'h0});
        u_core.acc(IRQ_STS_ADDR, '0, 1'b0);
        exp_rd.push_back({14'h0, bad, go});
        u_core.rest();
        irq_is((go & msk[0]) | (bad & msk[1]));
        u_core.acc(IRQ_STS_ADDR, 16'h3, 1'b1);
        u_core.rest();
        irq_is(1'b0);
    endtask
    initial begin
        #100_000;
        failures++;
        conclude();
    end
    initial begin
        rst_i = 1'b1;
        repeat (20) @(posedge core_clk_i);
        rst_i <= 1'b0;
        u_core.acc(CTRL_ADDR, '0, 1'b0);
        exp_rd.push_back('0);
        u_core.acc(KEY_ADDR, '0, 1'b0);
        exp_rd.push_back('0);
        u_core.acc(4'h9, '0, 1'b0);
        exp_rd.push_back('0);
        u_core.acc(CTRL_ADDR, 16'h7fff, 1'b1);
        u_core.acc(CTRL_ADDR, '0, 1'b0);
        exp_rd.push_back(16'h604f);
        u_core.acc(CTRL_ADDR, '0, 1'b1);
        u_core.acc(IRQ_STS_ADDR, 16'h3, 1'b1);
        setmask(2'b11);
        foreach (fixed[i]) launch(fixed[i], 2'd0);
        launch(16'h4001, 2'd1);
        launch(16'h4001, 2'd2);
        setmask(2'b01);
        launch(16'h0001, 2'd0);
        setmask(2'b11);
        repeat (8) begin
            r = $random(seed);
            launch(r[15:0], r[17:16]);
        end
        repeat (4) @(negedge core_clk_i);
        check(exp_rd.size() == 0 && exp_op.size() == 0, "results missing");
        conclude();
    end
endmodule // flash_self_program_sequencer_tb
